// ---- src/dpr_pkg.sv ----
// constants, types and reset values of the display power/reset init block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package dpr_pkg;

  // -------------------------------------------------------------------
  // widths and reset values
  // -------------------------------------------------------------------
  localparam int COL_W = 7;
  localparam int LINE_W = 6;
  localparam logic [COL_W-1:0] COL_RST = 7'h00;
  localparam logic [COL_W-1:0] COL_MAX = 7'h7F;
  localparam logic [LINE_W-1:0] LINE_RST = 6'h00;
  localparam logic [LINE_W-1:0] MUX_RST = 6'h3F;
  localparam logic [LINE_W-1:0] MUX_MIN = 6'h0F;
  localparam logic [7:0] CONTRAST_RST = 8'h7F;
  localparam logic [6:0] TWI_ADDR_BASE = 7'h3C;
  localparam logic [6:0] TWI_ADDR_ALT = 7'h3D;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // -------------------------------------------------------------------
  // pin vector positions and idle levels
  // -------------------------------------------------------------------
  localparam int NPIN = 6;
  localparam int PIN_INIT = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDIN = 3;
  localparam int PIN_DC = 4;
  localparam int PIN_ASEL = 5;
  // init idles low so the block starts in the reset state
  localparam logic [NPIN-1:0] PIN_IDLE = 6'h02;

  // -------------------------------------------------------------------
  // command codes
  // -------------------------------------------------------------------
  localparam logic [7:0] CMD_COL_LO = 8'h00;
  localparam logic [7:0] CMD_COL_HI = 8'h10;
  localparam logic [7:0] CMD_START = 8'h40;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
  localparam logic [7:0] CMD_SEG_REV = 8'hA1;
  localparam logic [7:0] CMD_FOLLOW_RAM = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON = 8'hA5;
  localparam logic [7:0] CMD_NORMAL = 8'hA6;
  localparam logic [7:0] CMD_INVERSE = 8'hA7;
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_COM_NORM = 8'hC0;
  localparam logic [7:0] CMD_COM_REV = 8'hC8;

  typedef enum logic [1:0] {
    ARG_NONE,
    ARG_CONTRAST,
    ARG_MUX
  } dpr_arg_t;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic disp_on;
    logic [LINE_W-1:0] mux_ratio;
    logic seg_remap;
    logic com_reverse;
    logic [LINE_W-1:0] start_line;
    logic [COL_W-1:0] column;
    logic [7:0] contrast;
    logic all_on;
    logic inverse;
  } dpr_cfg_t;

  localparam dpr_cfg_t CFG_RST = '{
    disp_on: 1'b0,
    mux_ratio: MUX_RST,
    seg_remap: 1'b0,
    com_reverse: 1'b0,
    start_line: LINE_RST,
    column: COL_RST,
    contrast: CONTRAST_RST,
    all_on: 1'b0,
    inverse: 1'b0
  };

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] stable;
    logic [7:0] shift;
    logic [2:0] bits;
    dpr_arg_t arg;
    dpr_cfg_t cfg;
    logic in_reset;
    logic byte_stb;
    logic [7:0] last_byte;
    logic last_dc;
    logic [6:0] twi_addr;
  } dpr_state_t;

endpackage : dpr_pkg

// ---- src/dpr_core.sv ----
// device-side reset state, serial command intake and init configuration
`timescale 1ns/100ps
`default_nettype none

module dpr_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic init_low_input_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic dc,
  input wire logic addr_sel,
  output var dpr_pkg::dpr_cfg_t cfg,
  output logic in_reset,
  output logic byte_stb,
  output logic [7:0] byte_val,
  output logic byte_is_data,
  output logic [6:0] twi_addr
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  dpr_pkg::dpr_state_t st_ff;
  dpr_pkg::dpr_state_t nxt_st;
  logic [dpr_pkg::NPIN-1:0] pins;
  logic [dpr_pkg::NPIN-1:0] filt;

  assign pins[dpr_pkg::PIN_INIT] = init_low_input_n;
  assign pins[dpr_pkg::PIN_CS] = cs_n;
  assign pins[dpr_pkg::PIN_SCLK] = sclk;
  assign pins[dpr_pkg::PIN_SDIN] = sdin;
  assign pins[dpr_pkg::PIN_DC] = dc;
  assign pins[dpr_pkg::PIN_ASEL] = addr_sel;

  // -------------------------------------------------------------------
  // pin filter: a level counts once stages two and three agree
  // -------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < dpr_pkg::NPIN; gi = gi + 1) begin : g_filt
      assign filt[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi] :
                        st_ff.stable[gi];
    end
  endgenerate

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic sclk_rise;
    logic got_byte;
    logic [7:0] word;
    logic word_dc;
    sclk_rise = 1'b0;
    got_byte = 1'b0;
    word = 8'h00;
    word_dc = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.stable = filt;
    nxt_st.byte_stb = 1'b0;

    // address follows the select pin continuously
    if (filt[dpr_pkg::PIN_ASEL]) begin
      nxt_st.twi_addr = dpr_pkg::TWI_ADDR_ALT;
    end else begin
      nxt_st.twi_addr = dpr_pkg::TWI_ADDR_BASE;
    end

    sclk_rise = filt[dpr_pkg::PIN_SCLK] &
                ~st_ff.stable[dpr_pkg::PIN_SCLK];

    if (!filt[dpr_pkg::PIN_INIT]) begin
      // config, shift register, bit count and pending argument pinned while the input stays low
      nxt_st.in_reset = 1'b1;
      nxt_st.cfg = dpr_pkg::CFG_RST;
      nxt_st.shift = 8'h00;
      nxt_st.bits = 3'h0;
      nxt_st.arg = dpr_pkg::ARG_NONE;
    end else begin
      nxt_st.in_reset = 1'b0;
      // deselect drops a partial byte so framing restarts clean
      if (filt[dpr_pkg::PIN_CS]) begin
        nxt_st.bits = 3'h0;
      end else if (sclk_rise) begin
        nxt_st.shift = {st_ff.shift[6:0], filt[dpr_pkg::PIN_SDIN]};
        nxt_st.bits = st_ff.bits + 3'h1;
        if (st_ff.bits == dpr_pkg::BIT_LAST) begin
          got_byte = 1'b1;
          word = {st_ff.shift[6:0], filt[dpr_pkg::PIN_SDIN]};
          word_dc = filt[dpr_pkg::PIN_DC];
        end
      end

      if (got_byte) begin
        nxt_st.byte_stb = 1'b1;
        nxt_st.last_byte = word;
        nxt_st.last_dc = word_dc;
        if (word_dc) begin
          // data write walks the column counter, wrapping at the end
          if (st_ff.cfg.column == dpr_pkg::COL_MAX) begin
            nxt_st.cfg.column = dpr_pkg::COL_RST;
          end else begin
            nxt_st.cfg.column = 7'(st_ff.cfg.column + 7'h01);
          end
        end else begin
          case (st_ff.arg)
            dpr_pkg::ARG_CONTRAST: begin
              nxt_st.cfg.contrast = word;
              nxt_st.arg = dpr_pkg::ARG_NONE;
            end
            dpr_pkg::ARG_MUX: begin
              // ratios below the minimum are ignored, not clamped
              if (word[5:0] >= dpr_pkg::MUX_MIN) begin
                nxt_st.cfg.mux_ratio = word[5:0];
              end
              nxt_st.arg = dpr_pkg::ARG_NONE;
            end
            dpr_pkg::ARG_NONE: begin
              if (word[7:4] == dpr_pkg::CMD_COL_LO[7:4]) begin
                nxt_st.cfg.column[3:0] = word[3:0];
              end else if (word[7:3] == dpr_pkg::CMD_COL_HI[7:3]) begin
                nxt_st.cfg.column[6:4] = word[2:0];
              end else if (word[7:6] == dpr_pkg::CMD_START[7:6]) begin
                nxt_st.cfg.start_line = word[5:0];
              end else begin
                case (word)
                  dpr_pkg::CMD_CONTRAST: nxt_st.arg = dpr_pkg::ARG_CONTRAST;
                  dpr_pkg::CMD_MUX: nxt_st.arg = dpr_pkg::ARG_MUX;
                  dpr_pkg::CMD_SEG_NORM: nxt_st.cfg.seg_remap = 1'b0;
                  dpr_pkg::CMD_SEG_REV: nxt_st.cfg.seg_remap = 1'b1;
                  dpr_pkg::CMD_FOLLOW_RAM: nxt_st.cfg.all_on = 1'b0;
                  dpr_pkg::CMD_ALL_ON: nxt_st.cfg.all_on = 1'b1;
                  dpr_pkg::CMD_NORMAL: nxt_st.cfg.inverse = 1'b0;
                  dpr_pkg::CMD_INVERSE: nxt_st.cfg.inverse = 1'b1;
                  dpr_pkg::CMD_DISP_OFF: nxt_st.cfg.disp_on = 1'b0;
                  dpr_pkg::CMD_DISP_ON: nxt_st.cfg.disp_on = 1'b1;
                  dpr_pkg::CMD_COM_NORM: nxt_st.cfg.com_reverse = 1'b0;
                  dpr_pkg::CMD_COM_REV: nxt_st.cfg.com_reverse = 1'b1;
                  default: begin
                    // unsupported codes leave the configuration alone
                  end
                endcase
              end
            end
            default: nxt_st.arg = dpr_pkg::ARG_NONE;
          endcase
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.s1 <= dpr_pkg::PIN_IDLE;
      st_ff.s2 <= dpr_pkg::PIN_IDLE;
      st_ff.s3 <= dpr_pkg::PIN_IDLE;
      st_ff.stable <= dpr_pkg::PIN_IDLE;
      st_ff.shift <= 8'h00;
      st_ff.bits <= 3'h0;
      st_ff.arg <= dpr_pkg::ARG_NONE;
      st_ff.cfg <= dpr_pkg::CFG_RST;
      st_ff.in_reset <= 1'b1;
      st_ff.byte_stb <= 1'b0;
      st_ff.last_byte <= 8'h00;
      st_ff.last_dc <= 1'b0;
      st_ff.twi_addr <= dpr_pkg::TWI_ADDR_BASE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------
  // outputs, all straight from the state register
  // -------------------------------------------------------------------
  assign cfg = st_ff.cfg;
  assign in_reset = st_ff.in_reset;
  assign byte_stb = st_ff.byte_stb;
  assign byte_val = st_ff.last_byte;
  assign byte_is_data = st_ff.last_dc;
  assign twi_addr = st_ff.twi_addr;

endmodule : dpr_core

`default_nettype wire

// ---- tb/dpr_monitor.sv ----
// assertion checker for the reset state and address choice of dpr_core
`timescale 1ns/100ps
`default_nettype none
module dpr_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic addr_sel,
  input wire dpr_pkg::dpr_cfg_t cfg,
  input wire logic in_reset,
  input wire logic byte_stb,
  input wire logic [6:0] twi_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // reset state, checked from the second cycle of a held init
  // ------------------------------------------------------------------
  sequence held_s;
    in_reset && $past(in_reset);
  endsequence
  chk_disp_off: assert property (held_s |-> !cfg.disp_on &&
    cfg.mux_ratio == dpr_pkg::MUX_RST) else $error("display not off");
  chk_map_norm: assert property (held_s |-> !cfg.seg_remap)
    else $error("segment map not normal");
  chk_shift_idle: assert property (held_s |-> !byte_stb)
    else $error("byte taken in reset");
  chk_start_zero: assert property (held_s |-> cfg.start_line == 6'h00)
    else $error("start line not zero");
  chk_col_zero: assert property (held_s |-> cfg.column == 7'h00)
    else $error("column not zero");
  chk_com_norm: assert property (held_s |-> !cfg.com_reverse)
    else $error("common scan reversed");
  chk_contrast_rst: assert property (held_s |-> cfg.contrast == 8'h7F)
    else $error("contrast not reset");
  chk_follow_ram: assert property (held_s |-> !cfg.all_on && !cfg.inverse)
    else $error("display mode not normal");
  // six samples cover the four-edge filter latency with margin
  chk_addr_base: assert property (!addr_sel [*6] |-> twi_addr == 7'h3C)
    else $error("base address wrong");
  chk_addr_alt: assert property (addr_sel [*6] |-> twi_addr == 7'h3D)
    else $error("alternate address wrong");
  cover property ($fell(in_reset));
  cover property (byte_stb);
  cover property (twi_addr == 7'h3D);
endmodule : dpr_monitor
`default_nettype wire

// ---- tb/dpr_host.sv ----
// host model driving the init, serial and address pins
`timescale 1ns/100ps
`default_nettype none
module dpr_host #(parameter int DELAY_CYC = 20) (
  input wire logic clk_sys,
  output logic init_low_input_n,
  output logic cs_n,
  output logic sclk,
  output logic sdin,
  output logic dc,
  output logic addr_sel
);
  initial begin
    init_low_input_n = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
    dc = 1'b0;
    addr_sel = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : hold
  // five cycles a phase, above the four the filter needs
  task automatic put_bit(input logic b, input logic d);
    cs_n = 1'b0;
    sdin = b;
    dc = d;
    sclk = 1'b0;
    hold(5);
    sclk = 1'b1;
    hold(5);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] v, input logic d);
    for (int i = 7; i >= 0; i--) put_bit(v[i], d);
    hold(2);
    cs_n = 1'b1;
    sdin = ~sdin;
    hold(4);
  endtask : send_byte
  // ------------------------------------------------------------------
  // init pin, address pin and panel settle wait
  // ------------------------------------------------------------------
  task automatic set_init(input logic v);
    init_low_input_n = v;
  endtask : set_init
  task automatic set_asel(input logic v);
    addr_sel = v;
  endtask : set_asel
  // stands in for the panel settle wait, shortened to keep runs short
  task automatic settle();
    hold(DELAY_CYC);
  endtask : settle
endmodule : dpr_host
`default_nettype wire

// ---- tb/display_power_reset_init_bench.sv ----
// self-checking bench for the display power/reset init block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module display_power_reset_init_bench;
  logic clk_sys, rst_n, init_n, cs_n, sclk, sdin, dc, asel;
  logic in_reset, byte_stb, byte_is_data;
  logic [7:0] byte_val;
  logic [6:0] twi_addr;
  dpr_pkg::dpr_cfg_t cfg, exp;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int stb_seen = 0;
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  dpr_host HOST(.clk_sys(clk_sys), .init_low_input_n(init_n), .cs_n(cs_n),
    .sclk(sclk), .sdin(sdin), .dc(dc), .addr_sel(asel));
  dpr_core DUT(.clk_sys(clk_sys), .rst_n(rst_n), .init_low_input_n(init_n),
    .cs_n(cs_n), .sclk(sclk), .sdin(sdin), .dc(dc), .addr_sel(asel),
    .cfg(cfg), .in_reset(in_reset), .byte_stb(byte_stb),
    .byte_val(byte_val), .byte_is_data(byte_is_data), .twi_addr(twi_addr));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 10000) begin
      bad_count++;
      wrap_up();
    end
  end
  // strobe is one cycle wide, so each pulse is seen at exactly one edge
  always @(posedge clk_sys) begin
    if (byte_stb === 1'b1) stb_seen++;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    while (in_reset !== 1'b0 && n < 20) begin
      HOST.hold(1);
      n++;
    end
    `CHK("in_reset", 1'b0, in_reset)
  endtask : wait_ready
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_setup();
    int stb0;
    logic [7:0] cmds [12];
    stb0 = stb_seen;
    cmds = '{8'hAE, 8'hA1, 8'hC8, 8'h81, 8'h20, 8'h45, 8'hA7, 8'hA5,
      8'hA8, 8'h1F, 8'h12, 8'h03};
    HOST.set_init(1'b1);
    wait_ready();
    foreach (cmds[i]) HOST.send_byte(cmds[i], 1'b0);
    HOST.send_byte(8'h00, 1'b1);
    HOST.settle();
    HOST.send_byte(8'hAF, 1'b0);
    exp = '{1'b1, 6'h1F, 1'b1, 1'b1, 6'h05, 7'h24, 8'h20, 1'b1, 1'b1};
    `CHK("cfg", exp, cfg)
    `CHK("byte_stb", 14, stb_seen - stb0)
  endtask : t_setup
  task automatic t_reinit();
    HOST.set_init(1'b0);
    HOST.hold(30);
    `CHK("cfg", dpr_pkg::CFG_RST, cfg)
    `CHK("in_reset", 1'b1, in_reset)
    HOST.set_init(1'b1);
    wait_ready();
    HOST.send_byte(8'h55, 1'b1);
    `CHK("column", 7'h01, cfg.column)
    `CHK("is_data", 1'b1, byte_is_data)
  endtask : t_reinit
  task automatic t_partial();
    int stb0;
    stb0 = stb_seen;
    for (int i = 0; i < 5; i++) HOST.put_bit(1'b1, 1'b0);
    HOST.set_init(1'b0);
    HOST.hold(10);
    HOST.set_init(1'b1);
    wait_ready();
    HOST.send_byte(8'hAF, 1'b0);
    `CHK("byte_val", 8'hAF, byte_val)
    `CHK("disp_on", 1'b1, cfg.disp_on)
    `CHK("byte_stb", 1, stb_seen - stb0)
  endtask : t_partial
  task automatic t_addr();
    HOST.set_asel(1'b1);
    HOST.hold(8);
    `CHK("twi_addr", 7'h3D, twi_addr)
    HOST.set_asel(1'b0);
    HOST.hold(8);
    `CHK("twi_addr", 7'h3C, twi_addr)
  endtask : t_addr
  // set then clear every mode bit, argument split by a data byte, wrap
  task automatic t_modes();
    logic [7:0] cmds [14];
    cmds = '{8'hA1, 8'hC8, 8'hA7, 8'hA5, 8'hA0, 8'hC0, 8'hA6, 8'hA4,
      8'hA8, 8'h05, 8'h81, 8'h33, 8'h17, 8'h0F};
    foreach (cmds[i]) begin
      HOST.send_byte(cmds[i], 1'b0);
      if (i == 10) HOST.send_byte(8'h00, 1'b1);
    end
    `CHK("column", 7'h7F, cfg.column)
    HOST.send_byte(8'h00, 1'b1);
    exp = dpr_pkg::CFG_RST;
    exp.disp_on = 1'b1;
    exp.contrast = 8'h33;
    `CHK("cfg", exp, cfg)
  endtask : t_modes
  task automatic t_power_down();
    HOST.send_byte(dpr_pkg::CMD_DISP_OFF, 1'b0);
    `CHK("disp_on", 1'b0, cfg.disp_on)
    HOST.settle();
  endtask : t_power_down
  // mid-run hard reset with the init pin already high
  task automatic t_hard_reset();
    rst_n = 1'b0;
    HOST.hold(2);
    `CHK("cfg", dpr_pkg::CFG_RST, cfg)
    `CHK("in_reset", 1'b1, in_reset)
    `CHK("twi_addr", 7'h3C, twi_addr)
    rst_n = 1'b1;
    wait_ready();
    `CHK("cfg", dpr_pkg::CFG_RST, cfg)
    `CHK("byte_stb", 1'b0, byte_stb)
  endtask : t_hard_reset
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    HOST.hold(4);
    `CHK("cfg", dpr_pkg::CFG_RST, cfg)
    `CHK("twi_addr", 7'h3C, twi_addr)
    t_setup();
    t_reinit();
    t_partial();
    t_addr();
    t_modes();
    t_power_down();
    t_hard_reset();
    wrap_up();
  end
endmodule : display_power_reset_init_bench
bind dpr_core dpr_monitor MON(.clk_sys(clk_sys), .rst_n(rst_n),
  .addr_sel(addr_sel), .cfg(cfg), .in_reset(in_reset),
  .byte_stb(byte_stb), .twi_addr(twi_addr));
`default_nettype wire
